//--- ebcr_pkg.sv
// constants and carrier types for the endpoint byte-count register bank
package ebcr_pkg;
   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_BULK_CTL = 8'hB4;
   localparam logic [7:0] IDX_CTRL_RX  = 8'hB5;
   localparam logic [7:0] IDX_CTRL_TX  = 8'hB6;
   localparam logic [7:0] IDX_INTR_RX  = 8'hB7;
   localparam logic [7:0] IDX_SEND     = 8'hB8;
   localparam logic [7:0] IDX_INTR_TX  = 8'hC7;
   localparam logic [7:0] IDX_A_HIGH   = 8'hCE;
   localparam logic [7:0] IDX_A_LOW    = 8'hCF;
   localparam logic [7:0] IDX_B_HIGH   = 8'hD1;
   localparam logic [7:0] IDX_B_LOW    = 8'hD2;
   // field positions
   localparam int BIT_FULL_PKT = 6;
   localparam int BIT_COMBINED = 7;
   localparam int BIT_DIR      = 6;
   localparam int BIT_FILL_SEL = 5;
   localparam int BIT_STALL_RX = 3;
   localparam int BIT_STALL_TX = 2;
   localparam int BIT_CTRL_GO  = 0;
   localparam int BIT_INTR_GO  = 1;
   // sram buffer bases
   localparam logic [10:0] CTRL_RX_BASE = 11'h000;
   localparam logic [10:0] CTRL_TX_BASE = 11'h040;
   localparam logic [10:0] INTR_RX_BASE = 11'h080;
   localparam logic [10:0] INTR_TX_BASE = 11'h0C0;
   localparam logic [10:0] BULK_A_BASE  = 11'h100;
   localparam logic [10:0] BULK_B_BASE  = 11'h300;
   // reset values and bus answers
   localparam logic [6:0] RST_EP_COUNT   = 7'h00;
   localparam logic [9:0] RST_BULK_COUNT = 10'h000;
   localparam logic [1:0] RESP_OKAY      = 2'h0;
   localparam logic [1:0] RESP_SLVERR    = 2'h2;

   // events from the serial interface engine
   typedef struct packed {
      logic        ctrl_rx_done;
      logic        intr_rx_done;
      logic        bulk_wr_done;
      logic [10:0] end_addr;
      logic        setup_rcvd;
      logic        stall_set_tx;
      logic        stall_set_rx;
      logic        stall_clr_tx;
      logic        stall_clr_rx;
      logic        set_config;
      logic        bus_reset;
   } ebcr_eng_s;

   // transmit request towards the engine
   typedef struct packed {
      logic        go;
      logic [6:0]  len;
      logic [10:0] base;
   } ebcr_tx_s;

   // bulk endpoint control towards the engine
   typedef struct packed {
      logic stall_tx;
      logic stall_rx;
      logic dir;
      logic fill_sel;
   } ebcr_bulk_s;
endpackage : ebcr_pkg

//--- ebcr_regs.sv
// endpoint byte-count and bulk buffer status registers behind an axi4-lite slave
//
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/10ps
module ebcr_regs #(
   parameter int AW = 12
) (
   // clock and reset
   input  wire logic                core_clk,
   input  wire logic                sys_rst,
   // axi4-lite write
   input  wire logic [AW-1:0]       s_axi_awaddr,
   input  wire logic                s_axi_awvalid,
   output logic                     s_axi_awready,
   input  wire logic [31:0]         s_axi_wdata,
   input  wire logic [3:0]          s_axi_wstrb,
   input  wire logic                s_axi_wvalid,
   output logic                     s_axi_wready,
   output logic [1:0]               s_axi_bresp,
   output logic                     s_axi_bvalid,
   input  wire logic                s_axi_bready,
   // axi4-lite read
   input  wire logic [AW-1:0]       s_axi_araddr,
   input  wire logic                s_axi_arvalid,
   output logic                     s_axi_arready,
   output logic [31:0]              s_axi_rdata,
   output logic [1:0]               s_axi_rresp,
   output logic                     s_axi_rvalid,
   input  wire logic                s_axi_rready,
   // engine side
   input  wire ebcr_pkg::ebcr_eng_s eng_i,
   output ebcr_pkg::ebcr_tx_s       ctrl_tx_o,
   output ebcr_pkg::ebcr_tx_s       intr_tx_o,
   output ebcr_pkg::ebcr_bulk_s     bulk_o
);

   typedef struct packed {
      logic                 aw_got;
      logic [AW-1:0]        aw_addr;
      logic                 w_got;
      logic [31:0]          w_data;
      logic                 w_lane0;
      logic                 awready;
      logic                 wready;
      logic                 bvalid;
      logic [1:0]           bresp;
      logic                 arready;
      logic                 rvalid;
      logic [1:0]           rresp;
      logic [31:0]          rdata;
      logic [6:0]           ctrl_rx;
      logic [6:0]           ctrl_tx;
      logic [6:0]           intr_rx;
      logic [6:0]           intr_tx;
      logic [9:0]           a_cnt;
      logic [9:0]           b_cnt;
      logic                 combined;
      logic                 dir;
      logic                 fill_sel;
      logic                 stall_tx;
      logic                 stall_rx;
      ebcr_pkg::ebcr_tx_s   ctrl_tx_out;
      ebcr_pkg::ebcr_tx_s   intr_tx_out;
      ebcr_pkg::ebcr_bulk_s bulk_out;
   } ebcr_state_s;

   ebcr_state_s st_q;
   ebcr_state_s st_d;
   logic        wr_commit;
   logic [7:0]  wr_idx;
   logic        wr_hit;
   logic [7:0]  wr_byte;

   // byte address to register index; misaligned or high bits give no hit
   function automatic logic [8:0] idx_of(input logic [AW-1:0] a);
      idx_of = {(a[1:0] == 2'h0) && (a[AW-1:10] == '0), a[9:2]};
   endfunction : idx_of

   // offset from buffer base; top bit is the full flag, the rest wrap
   function automatic logic [9:0] fill_of(input logic [10:0] addr,
                                          input logic [10:0] base);
      logic [10:0] off;
      off = addr - base;
      fill_of = off[9:0];
   endfunction : fill_of

   function automatic logic [6:0] ep_of(input logic [10:0] addr,
                                        input logic [10:0] base);
      logic [9:0] f;
      f = fill_of(addr, base);
      ep_of = f[6:0];
   endfunction : ep_of

   // read multiplexer: {hit, byte}
   function automatic logic [8:0] rd_mux(input logic [7:0] idx, input ebcr_state_s s);
      rd_mux = {1'b1, 8'h00};
      case (idx)
         ebcr_pkg::IDX_BULK_CTL: rd_mux[7:0] = {s.combined, s.dir, s.fill_sel, 1'b0,
                                                s.stall_rx & ~s.combined, s.stall_tx, 2'h0};
         ebcr_pkg::IDX_CTRL_RX:  rd_mux[7:0] = {1'b0, s.ctrl_rx};
         ebcr_pkg::IDX_CTRL_TX:  rd_mux[7:0] = {1'b0, s.ctrl_tx};
         ebcr_pkg::IDX_INTR_RX:  rd_mux[7:0] = {1'b0, s.intr_rx};
         ebcr_pkg::IDX_SEND:     rd_mux[7:0] = 8'h00;
         ebcr_pkg::IDX_INTR_TX:  rd_mux[7:0] = {1'b0, s.intr_tx};
         ebcr_pkg::IDX_A_HIGH:   rd_mux[7:0] = {6'h00, s.a_cnt[9:8]};
         ebcr_pkg::IDX_A_LOW:    rd_mux[7:0] = s.a_cnt[7:0];
         ebcr_pkg::IDX_B_HIGH:   rd_mux[7:0] = {6'h00, s.b_cnt[9:8]};
         ebcr_pkg::IDX_B_LOW:    rd_mux[7:0] = s.b_cnt[7:0];
         default:                rd_mux = 9'h000;
      endcase
   endfunction : rd_mux

   always_comb
   begin
      logic [8:0] wi;
      logic [8:0] ri;
      logic [8:0] rm;
      logic       aw_hs;
      logic       w_hs;
      logic       clr_tx;
      logic       clr_rx;
      logic       sw_tx;
      logic       sw_rx;
      logic [8:0] wm;
      st_d = st_q;
      ri = 9'h000;
      rm = 9'h000;
      aw_hs = s_axi_awvalid & st_q.awready;
      w_hs = s_axi_wvalid & st_q.wready;
      if (aw_hs)
      begin
         st_d.aw_got = 1'b1;
         st_d.aw_addr = s_axi_awaddr;
      end
      if (w_hs)
      begin
         st_d.w_got = 1'b1;
         st_d.w_data = s_axi_wdata;
         st_d.w_lane0 = s_axi_wstrb[0];
      end
      // address and data may arrive in either order
      wr_commit = st_d.aw_got & st_d.w_got & ~st_q.bvalid;
      wi = idx_of(st_d.aw_addr);
      wr_idx = wi[7:0];
      wm = rd_mux(wi[7:0], st_q);
      wr_hit = wr_commit & wi[8] & wm[8];
      wr_byte = st_d.w_lane0 ? st_d.w_data[7:0] : 8'h00;
      if (wr_commit)
      begin
         st_d.aw_got = 1'b0;
         st_d.w_got = 1'b0;
         st_d.bvalid = 1'b1;
         st_d.bresp = wr_hit ? ebcr_pkg::RESP_OKAY : ebcr_pkg::RESP_SLVERR;
      end
      else if (st_q.bvalid & s_axi_bready)
         st_d.bvalid = 1'b0;
      st_d.awready = ~st_d.aw_got & ~st_d.bvalid;
      st_d.wready = ~st_d.w_got & ~st_d.bvalid;
      // read answers one cycle after the address is taken
      if (s_axi_arvalid & st_q.arready)
      begin
         ri = idx_of(s_axi_araddr);
         rm = rd_mux(ri[7:0], st_q);
         st_d.rvalid = 1'b1;
         st_d.rdata = {24'h000000, rm[7:0]};
         st_d.rresp = (ri[8] & rm[8]) ? ebcr_pkg::RESP_OKAY : ebcr_pkg::RESP_SLVERR;
      end
      else if (st_q.rvalid & s_axi_rready)
         st_d.rvalid = 1'b0;
      st_d.arready = ~st_d.rvalid;

      // firmware writes; lane 0 only, others ignored
      sw_tx = 1'b0;
      sw_rx = 1'b0;
      st_d.ctrl_tx_out.go = 1'b0;
      st_d.intr_tx_out.go = 1'b0;
      if (wr_hit & st_d.w_lane0)
      begin
         case (wr_idx)
            ebcr_pkg::IDX_BULK_CTL:
            begin
               st_d.combined = wr_byte[ebcr_pkg::BIT_COMBINED];
               st_d.dir = wr_byte[ebcr_pkg::BIT_DIR];
               st_d.fill_sel = wr_byte[ebcr_pkg::BIT_FILL_SEL];
               if (wr_byte[ebcr_pkg::BIT_FILL_SEL])
                  st_d.b_cnt = ebcr_pkg::RST_BULK_COUNT;
               else
                  st_d.a_cnt = ebcr_pkg::RST_BULK_COUNT;
               sw_tx = wr_byte[ebcr_pkg::BIT_STALL_TX];
               sw_rx = wr_byte[ebcr_pkg::BIT_STALL_RX];
            end
            ebcr_pkg::IDX_CTRL_TX: st_d.ctrl_tx = wr_byte[6:0];
            ebcr_pkg::IDX_INTR_TX: st_d.intr_tx = wr_byte[6:0];
            ebcr_pkg::IDX_SEND:
            begin
               // go with zero count sends empty packet
               st_d.ctrl_tx_out.go = wr_byte[ebcr_pkg::BIT_CTRL_GO];
               st_d.intr_tx_out.go = wr_byte[ebcr_pkg::BIT_INTR_GO];
            end
            default: st_d.dir = st_q.dir;
         endcase
      end
      st_d.ctrl_tx_out.len = st_q.ctrl_tx;
      st_d.ctrl_tx_out.base = ebcr_pkg::CTRL_TX_BASE;
      st_d.intr_tx_out.len = st_q.intr_tx;
      st_d.intr_tx_out.base = ebcr_pkg::INTR_TX_BASE;

      // engine events win over clears in the same cycle
      // setup clears interrupt receive count
      if (eng_i.setup_rcvd)
         st_d.intr_rx = ebcr_pkg::RST_EP_COUNT;
      // loaded on completion from end address
      if (eng_i.ctrl_rx_done)
         st_d.ctrl_rx = ep_of(eng_i.end_addr, ebcr_pkg::CTRL_RX_BASE);
      if (eng_i.intr_rx_done)
         st_d.intr_rx = ep_of(eng_i.end_addr, ebcr_pkg::INTR_RX_BASE);
      // full packet wraps count, flag set
      if (eng_i.bulk_wr_done & ~st_q.fill_sel)
         st_d.a_cnt = fill_of(eng_i.end_addr, ebcr_pkg::BULK_A_BASE);
      if (eng_i.bulk_wr_done & st_q.fill_sel)
         st_d.b_cnt = fill_of(eng_i.end_addr, ebcr_pkg::BULK_B_BASE);

      // stall cleared only by host events
      clr_tx = eng_i.stall_clr_tx | eng_i.set_config | eng_i.bus_reset |
               (st_q.combined & eng_i.stall_clr_rx);
      clr_rx = eng_i.stall_clr_rx | eng_i.set_config | eng_i.bus_reset |
               (st_q.combined & eng_i.stall_clr_tx);
      if (eng_i.stall_set_tx | sw_tx)
         st_d.stall_tx = 1'b1;
      else if (clr_tx)
         st_d.stall_tx = 1'b0;
      // a write that leaves combined mode may set bit 3 at once
      if ((eng_i.stall_set_rx & ~st_q.combined) | (sw_rx & ~st_d.combined))
         st_d.stall_rx = 1'b1;
      else if (clr_rx)
         st_d.stall_rx = 1'b0;
      st_d.bulk_out.stall_tx = st_d.stall_tx;
      st_d.bulk_out.stall_rx = st_d.combined ? st_d.stall_tx : st_d.stall_rx;
      st_d.bulk_out.dir = st_d.dir;
      st_d.bulk_out.fill_sel = st_d.fill_sel;
   end

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
         st_q <= '0;
      else
         st_q <= st_d;
   end

   assign s_axi_awready = st_q.awready;
   assign s_axi_wready = st_q.wready;
   assign s_axi_bvalid = st_q.bvalid;
   assign s_axi_bresp = st_q.bresp;
   assign s_axi_arready = st_q.arready;
   assign s_axi_rvalid = st_q.rvalid;
   assign s_axi_rresp = st_q.rresp;
   assign s_axi_rdata = st_q.rdata;
   assign ctrl_tx_o = st_q.ctrl_tx_out;
   assign intr_tx_o = st_q.intr_tx_out;
   assign bulk_o = st_q.bulk_out;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);

   sequence rd_bulk_ctl_s;
      s_axi_arvalid && s_axi_arready && s_axi_araddr == AW'({ebcr_pkg::IDX_BULK_CTL, 2'h0})
      && st_q.combined;
   endsequence
   sequence go_write_s;
      wr_hit && st_d.w_lane0 && wr_idx == ebcr_pkg::IDX_SEND && wr_byte[ebcr_pkg::BIT_CTRL_GO];
   endsequence

   ctrl_rx_load_a: assert property (eng_i.ctrl_rx_done |=>
      bulk_o.dir == $past(st_d.dir) && st_q.ctrl_rx == $past(eng_i.end_addr[6:0]))
      else $error("control receive count not loaded");
   intr_clear_a: assert property (eng_i.setup_rcvd && !eng_i.intr_rx_done |=>
      st_q.intr_rx == 7'h00) else $error("interrupt receive count not cleared");
   both_stall_a: assert property (st_q.combined && st_q.stall_tx |->
      bulk_o.stall_tx && bulk_o.stall_rx) else $error("combined stall not on both");
   joint_clear_a: assert property (st_q.combined && eng_i.stall_clr_rx && !eng_i.stall_set_tx
      && !(wr_hit && wr_idx == ebcr_pkg::IDX_BULK_CTL) |=> !bulk_o.stall_tx && !bulk_o.stall_rx)
      else $error("stall not cleared on both");
   rx_stall_rsvd_a: assert property (rd_bulk_ctl_s ##1 s_axi_rvalid |->
      !s_axi_rdata[ebcr_pkg::BIT_STALL_RX]) else $error("reserved stall bit nonzero");
   fill_a_load_a: assert property (eng_i.bulk_wr_done && !st_q.fill_sel |=>
      st_q.a_cnt == $past(eng_i.end_addr[9:0]) - 10'h100) else $error("buffer a count wrong");
   fill_clear_a: assert property (wr_hit && st_d.w_lane0 && wr_idx == ebcr_pkg::IDX_BULK_CTL
      && wr_byte[ebcr_pkg::BIT_FILL_SEL] && !eng_i.bulk_wr_done |=> st_q.b_cnt == 10'h000
      && bulk_o.fill_sel) else $error("buffer b not selected and cleared");
   send_go_a: assert property (go_write_s |=> ctrl_tx_o.go
      && ctrl_tx_o.len == $past(st_q.ctrl_tx) ##1 !ctrl_tx_o.go) else $error("send go wrong");
   stall_hold_a: assert property (st_q.stall_tx && !eng_i.stall_clr_tx && !eng_i.stall_clr_rx
      && !eng_i.set_config && !eng_i.bus_reset |=> st_q.stall_tx) else $error("stall dropped");
endmodule : ebcr_regs

//--- ebcr_regs_test.sv
// self-checking bench for the endpoint byte-count register bank
`timescale 1ns/10ps
module ebcr_regs_test;
   logic                 core_clk = 1'b0;
   logic                 sys_rst = 1'b1;
   logic [11:0]          awaddr, araddr;
   logic                 awvalid, wvalid, bready, arvalid, rready;
   logic [31:0]          wdata, rdata;
   logic [3:0]           wstrb;
   logic                 awready, wready, bvalid, arready, rvalid;
   logic [1:0]           bresp, rresp;
   ebcr_pkg::ebcr_eng_s  eng;
   ebcr_pkg::ebcr_tx_s   ctrl_tx, intr_tx, sent;
   ebcr_pkg::ebcr_bulk_s bulk;
   int                   go_cnt;
   int                   err_total = 0;
   int                   num_checks = 0;

   always #4 core_clk = ~core_clk;

   ebcr_regs u_ebcr_regs (.core_clk(core_clk), .sys_rst(sys_rst),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .eng_i(eng), .ctrl_tx_o(ctrl_tx), .intr_tx_o(intr_tx), .bulk_o(bulk));

   ebcr_sie_model u_ebcr_sie_model (.core_clk(core_clk), .sys_rst(sys_rst), .eng_o(eng),
      .ctrl_tx_i(ctrl_tx), .intr_tx_i(intr_tx), .sent_o(sent), .go_cnt_o(go_cnt));

   task automatic final_report;
      $display("checks=%0d errors=%0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : final_report

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // a wait that runs out ends the run
   task automatic lim(input int n);
      if (n >= 40)
      begin
         chk(32'h0, 32'h1);
         final_report();
      end
   endtask : lim

   task automatic wr(input logic [7:0] idx, input logic [7:0] val, input logic [1:0] er);
      int n;
      n = 0;
      @(posedge core_clk);
      awaddr  <= {2'b00, idx, 2'b00};
      wdata   <= {24'h0, val};
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      do
      begin
         @(posedge core_clk);
         n++;
         if (awready === 1'b1)
            awvalid <= 1'b0;
         if (wready === 1'b1)
            wvalid <= 1'b0;
      end
      while (bvalid !== 1'b1 && n < 40);
      bready <= 1'b0;
      lim(n);
      chk({30'h0, bresp}, {30'h0, er});
   endtask : wr

   task automatic rd(input logic [7:0] idx, input logic [7:0] m, input logic [7:0] e, input logic [1:0] er);
      int n;
      n = 0;
      @(posedge core_clk);
      araddr  <= {2'b00, idx, 2'b00};
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do
      begin
         @(posedge core_clk);
         n++;
         if (arready === 1'b1)
            arvalid <= 1'b0;
      end
      while (rvalid !== 1'b1 && n < 40);
      rready <= 1'b0;
      lim(n);
      chk(rdata & {24'h0, m}, {24'h0, e});
      chk({30'h0, rresp}, {30'h0, er});
   endtask : rd

   task automatic ev(input int k, input logic [10:0] a);
      u_ebcr_sie_model.fire(k, a);
   endtask : ev

   task automatic st(input logic [1:0] e);
      @(posedge core_clk);
      chk({30'h0, bulk.stall_tx, bulk.stall_rx}, {30'h0, e});
   endtask : st

   task automatic sc_reset;
      logic [7:0] idx [8];
      idx = '{ebcr_pkg::IDX_CTRL_RX, ebcr_pkg::IDX_CTRL_TX, ebcr_pkg::IDX_INTR_RX, ebcr_pkg::IDX_INTR_TX,
              ebcr_pkg::IDX_A_HIGH, ebcr_pkg::IDX_A_LOW, ebcr_pkg::IDX_B_HIGH, ebcr_pkg::IDX_B_LOW};
      foreach (idx[i])
         rd(idx[i], 8'hFF, 8'h00, ebcr_pkg::RESP_OKAY);
      wr(ebcr_pkg::IDX_CTRL_RX, 8'hFF, ebcr_pkg::RESP_OKAY);
      rd(ebcr_pkg::IDX_CTRL_RX, 8'hFF, 8'h00, ebcr_pkg::RESP_OKAY);
      wr(8'hC0, 8'h01, ebcr_pkg::RESP_SLVERR);
      rd(8'hC0, 8'hFF, 8'h00, ebcr_pkg::RESP_SLVERR);
   endtask : sc_reset

   task automatic sc_rx;
      ev(0, ebcr_pkg::CTRL_RX_BASE + 11'h012);
      rd(ebcr_pkg::IDX_CTRL_RX, 8'hFF, 8'h12, ebcr_pkg::RESP_OKAY);
      ev(0, ebcr_pkg::CTRL_RX_BASE + 11'h040);
      rd(ebcr_pkg::IDX_CTRL_RX, 8'hFF, 8'h40, ebcr_pkg::RESP_OKAY);
      ev(1, ebcr_pkg::INTR_RX_BASE + 11'h025);
      rd(ebcr_pkg::IDX_INTR_RX, 8'hFF, 8'h25, ebcr_pkg::RESP_OKAY);
      ev(3, 11'h000);
      rd(ebcr_pkg::IDX_INTR_RX, 8'hFF, 8'h00, ebcr_pkg::RESP_OKAY);
   endtask : sc_rx

   task automatic sc_tx;
      wr(ebcr_pkg::IDX_CTRL_TX, 8'hFF, ebcr_pkg::RESP_OKAY);
      rd(ebcr_pkg::IDX_CTRL_TX, 8'hFF, 8'h7F, ebcr_pkg::RESP_OKAY);
      wr(ebcr_pkg::IDX_CTRL_TX, 8'h00, ebcr_pkg::RESP_OKAY);
      wr(ebcr_pkg::IDX_SEND, 8'h01, ebcr_pkg::RESP_OKAY);
      rd(ebcr_pkg::IDX_SEND, 8'hFF, 8'h00, ebcr_pkg::RESP_OKAY);
      chk({14'h0, sent.len, sent.base}, {14'h0, 7'h00, ebcr_pkg::CTRL_TX_BASE});
      wr(ebcr_pkg::IDX_INTR_TX, 8'h40, ebcr_pkg::RESP_OKAY);
      wr(ebcr_pkg::IDX_SEND, 8'h02, ebcr_pkg::RESP_OKAY);
      rd(ebcr_pkg::IDX_INTR_TX, 8'hFF, 8'h40, ebcr_pkg::RESP_OKAY);
      chk({14'h0, sent.len, sent.base}, {14'h0, 7'h40, ebcr_pkg::INTR_TX_BASE});
      chk(go_cnt, 2);
   endtask : sc_tx

   task automatic sc_bulk;
      wr(ebcr_pkg::IDX_BULK_CTL, 8'h00, ebcr_pkg::RESP_OKAY);
      ev(2, ebcr_pkg::BULK_A_BASE + 11'h123);
      rd(ebcr_pkg::IDX_A_HIGH, 8'hFF, 8'h01, ebcr_pkg::RESP_OKAY);
      rd(ebcr_pkg::IDX_A_LOW, 8'hFF, 8'h23, ebcr_pkg::RESP_OKAY);
      wr(ebcr_pkg::IDX_BULK_CTL, 8'h40, ebcr_pkg::RESP_OKAY);
      wr(ebcr_pkg::IDX_BULK_CTL, 8'h60, ebcr_pkg::RESP_OKAY);
      chk({30'h0, bulk.dir, bulk.fill_sel}, {30'h0, 2'b11});
      ev(2, ebcr_pkg::BULK_B_BASE + 11'h200);
      rd(ebcr_pkg::IDX_B_HIGH, 8'hFF, 8'h02, ebcr_pkg::RESP_OKAY);
      rd(ebcr_pkg::IDX_B_LOW, 8'hFF, 8'h00, ebcr_pkg::RESP_OKAY);
      wr(ebcr_pkg::IDX_BULK_CTL, 8'h20, ebcr_pkg::RESP_OKAY);
      rd(ebcr_pkg::IDX_B_HIGH, 8'hFF, 8'h00, ebcr_pkg::RESP_OKAY);
   endtask : sc_bulk

   task automatic sc_stall;
      wr(ebcr_pkg::IDX_BULK_CTL, 8'h84, ebcr_pkg::RESP_OKAY);
      st(2'b11);
      rd(ebcr_pkg::IDX_BULK_CTL, 8'h08, 8'h00, ebcr_pkg::RESP_OKAY);
      ev(4, 11'h000);
      st(2'b00);
      wr(ebcr_pkg::IDX_BULK_CTL, 8'h08, ebcr_pkg::RESP_OKAY);
      ev(6, 11'h000);
      st(2'b11);
      ev(8, 11'h000);
      st(2'b01);
      ev(5, 11'h000);
      st(2'b00);
      ev(6, 11'h000);
      ev(7, 11'h000);
      st(2'b00);
      ev(9, 11'h000);
      st(2'b01);
      wr(ebcr_pkg::IDX_BULK_CTL, 8'h80, ebcr_pkg::RESP_OKAY);
      ev(9, 11'h000);
      st(2'b00);
      rd(ebcr_pkg::IDX_BULK_CTL, 8'h08, 8'h00, ebcr_pkg::RESP_OKAY);
   endtask : sc_stall

   initial
   begin
      {awaddr, araddr, awvalid, wvalid, bready, arvalid, rready, wdata} = '0;
      wstrb = 4'h1;
      repeat (8) @(posedge core_clk);
      sys_rst <= 1'b0;
      sc_reset();
      sc_rx();
      sc_tx();
      sc_bulk();
      sc_stall();
      final_report();
   end
endmodule : ebcr_regs_test

//--- ebcr_sie_model.sv
// behavioural model of the serial interface engine facing the register bank
`timescale 1ns/10ps
module ebcr_sie_model (
   // clock and reset
   input  wire logic                core_clk,
   input  wire logic                sys_rst,
   // towards the register bank
   output ebcr_pkg::ebcr_eng_s      eng_o,
   input  wire ebcr_pkg::ebcr_tx_s  ctrl_tx_i,
   input  wire ebcr_pkg::ebcr_tx_s  intr_tx_i,
   // observed transmissions
   output ebcr_pkg::ebcr_tx_s       sent_o,
   output int                       go_cnt_o
);
   initial
   begin
      eng_o    = '0;
      sent_o   = '0;
      go_cnt_o = 0;
   end

   always @(posedge core_clk)
   begin
      if (sys_rst)
         go_cnt_o <= 0;
      else if (ctrl_tx_i.go || intr_tx_i.go)
      begin
         sent_o   <= ctrl_tx_i.go ? ctrl_tx_i : intr_tx_i;
         go_cnt_o <= go_cnt_o + 1;
      end
   end

   task automatic fire(input int kind, input logic [10:0] ea);
      ebcr_pkg::ebcr_eng_s ev;
      ebcr_pkg::ebcr_eng_s idle;
      ev = '0;
      idle = '0;
      ev.end_addr = ea;
      // address is stale once the pulse ends
      idle.end_addr = ~ea;
      case (kind)
         0: ev.ctrl_rx_done = 1'b1;
         1: ev.intr_rx_done = 1'b1;
         2: ev.bulk_wr_done = 1'b1;
         3: ev.setup_rcvd = 1'b1;
         4: ev.stall_clr_rx = 1'b1;
         5: ev.set_config = 1'b1;
         6: ev.stall_set_tx = 1'b1;
         7: ev.bus_reset = 1'b1;
         9: ev.stall_set_rx = 1'b1;
         default: ev.stall_clr_tx = 1'b1;
      endcase
      @(posedge core_clk);
      eng_o <= ev;
      @(posedge core_clk);
      eng_o <= idle;
   endtask : fire
endmodule : ebcr_sie_model
